// File: sarcc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: system clock of 250 MHz
// Notes:   field codes and reset values live here only
package sarcc_pkg;
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned CONV_CLK_MAX_KHZ = 2500;
    // least divider keeping the converter clock within its limit
    localparam int unsigned DIV_MIN =
        (CLK_MHZ * 1000 + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
    localparam int unsigned CONV_CLOCKS     = 16;
    localparam int unsigned TRACK_CLOCKS    = 3;
    localparam logic [7:0]  DIV_RESET       = 8'hff;
    localparam logic [2:0]  GAIN_RESET      = 3'h0;
    localparam logic [3:0]  CHAN_RESET      = 4'h0;
    localparam logic [3:0]  PAIR_RESET      = 4'h0;
    localparam logic [15:0] GT_RESET        = 16'hffff;
    localparam logic [15:0] LT_RESET        = 16'h0000;
    localparam int unsigned DONE_FLAG_BIT   = 5;
    localparam int unsigned SAMPLE_BITS     = 12;
    localparam logic [2:0]  GAIN_X1         = 3'h0;
    localparam logic [2:0]  GAIN_X2         = 3'h1;
    localparam logic [2:0]  GAIN_X4         = 3'h2;
    localparam logic [2:0]  GAIN_X8         = 3'h3;
    localparam logic [2:0]  GAIN_X16        = 3'h4;
    localparam logic [2:0]  GAIN_X0P5       = 3'h6;
    localparam logic [3:0]  CHAN_TEMP       = 4'h8;

    typedef enum logic [1:0] {
        SARCC_START_SW   = 2'b00,
        SARCC_START_T3   = 2'b01,
        SARCC_START_EXT  = 2'b10,
        SARCC_START_T2   = 2'b11
    } sarcc_start_t;

    typedef enum logic [1:0] {
        SARCC_IDLE   = 2'b00,
        SARCC_TRACK  = 2'b01,
        SARCC_CONV   = 2'b10,
        SARCC_FINISH = 2'b11
    } sarcc_state_t;
endpackage

// File: sarcc_clkdiv.sv
// Purpose: converter clock tick generator
// Assumes: dividers below the least legal value are clamped
// Notes:   one-cycle tick per converter clock, restarts with run
`timescale 1ns/1ns
module sarcc_clkdiv (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [7:0] divider,
    output logic            tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] limit;
    logic       tick_next;

    always_comb begin
        // clamp keeps the converter clock within its rating
        limit = (divider < 8'(sarcc_pkg::DIV_MIN)) ?
                8'(sarcc_pkg::DIV_MIN) : divider;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = 8'h00;
        end else if (cnt_reg >= limit - 8'h01) begin
            cnt_next = 8'h00;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule

// File: sarcc_window.sv
// Purpose: window comparator on the justified data word
// Assumes: operands registered by the caller
// Notes:   purely combinational
`timescale 1ns/1ns
module sarcc_window (
    input  wire logic [15:0] word,
    input  wire logic [15:0] ltLimit,
    input  wire logic [15:0] gtLimit,
    input  wire logic        signedMode,
    output logic             hit
);
    function automatic logic less(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic sgn);
        if (sgn) begin
            less = $signed(a) < $signed(b);
        end else begin
            less = a < b;
        end
    endfunction

    logic belowLt;
    logic aboveGt;
    logic inverted;

    always_comb begin
        belowLt = less(word, ltLimit, signedMode);
        aboveGt = less(gtLimit, word, signedMode);
        inverted = less(gtLimit, ltLimit, signedMode);
        if (inverted) begin
            hit = belowLt && aboveGt;
        end else begin
            hit = belowLt || aboveGt;
        end
    end
endmodule

// File: sar_adc_conversion_control.sv
// Purpose: sequencing, triggers, flags and result placement of the converter
// Assumes: analog core returns a 12-bit sample when sampleValid pulses
// Notes:   control and status are plain ports
// Functional notes
// - subsystem runs only while enabled, else held in shutdown
// - nine channels, eight external plus temperature sensor
// - input pairs selectable differential or single-ended, reset single
// - three-bit gain field picks 0.5,1,2,4,8,16; unity after reset
// - converter clock equals system clock divided by divider field, dividers below 100 clamped to 100
// - two-bit start mode picks one of four trigger sources
// - busy high whole conversion, clears itself on completion
// - busy falling edge at completion sets done flag, and interrupt request when doneIntEnable
// - result placed left or right justified per justify bit
// - tracking-mode zero tracks continuously when not converting
// - tracking-mode one tracks three converter clocks after trigger, except with external start
// - low-power with external start tracks while low, converts on rise
// - tracking off while chip is in standby or sleep
// - sixteen converter clocks per conversion, clock at most 2.5 MHz
// - each end of conversion compares limits, sets window flag
// - inverted limits flag results strictly between them
// - normal limits flag results below less or above greater
// - differential comparisons signed on the justified word
// - differential results two's complement, sign extended when right
`timescale 1ns/1ns
module sar_adc_conversion_control (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        convEnable,
    input  wire logic [1:0]  startMode,
    input  wire logic        swStart,
    input  wire logic        timer3Overflow,
    input  wire logic        timer2Overflow,
    input  wire logic        extConvertStart,
    input  wire logic        chipSleep,
    input  wire logic        trackingMode,
    input  wire logic        leftJustify,
    input  wire logic        doneFlagClear,
    input  wire logic        windowFlagClear,
    input  wire logic        doneIntEnable,
    input  wire logic        cfgWrite,
    input  wire logic [3:0]  channelSelIn,
    input  wire logic [3:0]  pairConfigIn,
    input  wire logic [2:0]  gainSelIn,
    input  wire logic [7:0]  clockDividerIn,
    input  wire logic [15:0] ltLimitIn,
    input  wire logic [15:0] gtLimitIn,
    input  wire logic        sampleValid,
    input  wire logic [11:0] sampleData,
    output logic             convBusy,
    output logic             convDoneFlag,
    output logic             doneIrq,
    output logic             windowFlag,
    output logic [7:0]       resultHighByte,
    output logic [7:0]       resultLowByte,
    output logic             analogPowerOn,
    output logic             trackEnable,
    output logic             holdSample,
    output logic [3:0]       channelSelect,
    output logic [3:0]       pairConfig,
    output logic [2:0]       gainSelect,
    output logic             diffChannel
);
    logic rstSync1;
    logic rstSync2;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    assign rst_n = rstSync2;

    // pin: three stages, accepted when last two agree
    logic extS1;
    logic extS2;
    logic extS3;
    logic extLevel_reg;
    logic extLevel_next;
    logic extRise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extS1 <= 1'b0;
            extS2 <= 1'b0;
            extS3 <= 1'b0;
        end else if (ce) begin
            extS1 <= extConvertStart;
            extS2 <= extS1;
            extS3 <= extS2;
        end
    end

    always_comb begin
        extLevel_next = (extS2 == extS3) ? extS2 : extLevel_reg;
        extRise = extLevel_next && !extLevel_reg;
    end

    // configuration registers
    logic [3:0]  chan_reg;
    logic [3:0]  chan_next;
    logic [3:0]  pair_reg;
    logic [3:0]  pair_next;
    logic [2:0]  gain_reg;
    logic [2:0]  gain_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic [15:0] lt_reg;
    logic [15:0] lt_next;
    logic [15:0] gt_reg;
    logic [15:0] gt_next;

    function automatic logic isDiff(input logic [3:0] ch,
                                    input logic [3:0] pairs);
        // temperature codes are never differential
        if (ch >= sarcc_pkg::CHAN_TEMP) begin
            isDiff = 1'b0;
        end else begin
            isDiff = pairs[ch[2:1]];
        end
    endfunction

    always_comb begin
        chan_next = chan_reg;
        pair_next = pair_reg;
        gain_next = gain_reg;
        div_next = div_reg;
        lt_next = lt_reg;
        gt_next = gt_reg;
        if (cfgWrite) begin
            // codes above temperature alias to it
            chan_next = channelSelIn[3] ? sarcc_pkg::CHAN_TEMP
                                        : channelSelIn;
            pair_next = pairConfigIn;
            gain_next = gainSelIn;
            div_next = clockDividerIn;
            lt_next = ltLimitIn;
            gt_next = gtLimitIn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_reg <= sarcc_pkg::CHAN_RESET;
            pair_reg <= sarcc_pkg::PAIR_RESET;
            gain_reg <= sarcc_pkg::GAIN_RESET;
            div_reg <= sarcc_pkg::DIV_RESET;
            lt_reg <= sarcc_pkg::LT_RESET;
            gt_reg <= sarcc_pkg::GT_RESET;
            extLevel_reg <= 1'b0;
        end else if (ce) begin
            chan_reg <= chan_next;
            pair_reg <= pair_next;
            gain_reg <= gain_next;
            div_reg <= div_next;
            lt_reg <= lt_next;
            gt_reg <= gt_next;
            extLevel_reg <= extLevel_next;
        end
    end

    // converter clock tick
    logic sarTick;

    sarcc_clkdiv u_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .run     (convBusy),
        .divider (div_reg),
        .tick    (sarTick)
    );

    // sequencer
    sarcc_pkg::sarcc_state_t state_reg;
    sarcc_pkg::sarcc_state_t state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic        busy_next;
    logic        done_reg;
    logic        done_next;
    logic        irq_next;
    logic        win_next;
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic [11:0] sample_reg;
    logic [11:0] sample_next;
    logic        track_next;
    logic        hold_next;
    logic        trigger;
    logic        endConv;
    logic        lowPowerExt;
    logic        winHit;
    logic [15:0] justified;
    logic        diffNow;

    always_comb begin
        diffNow = isDiff(chan_reg, pair_reg);
        case (sarcc_pkg::sarcc_start_t'(startMode))
            sarcc_pkg::SARCC_START_SW:  trigger = swStart;
            sarcc_pkg::SARCC_START_T3:  trigger = timer3Overflow;
            sarcc_pkg::SARCC_START_EXT: trigger = extRise;
            default:                    trigger = timer2Overflow;
        endcase
        lowPowerExt = trackingMode &&
            (startMode == sarcc_pkg::SARCC_START_EXT);
        // justification, sign extended for right-justified differential readings
        if (leftJustify) begin
            justified = {sample_reg, 4'h0};
        end else if (diffNow) begin
            justified = {{4{sample_reg[11]}}, sample_reg};
        end else begin
            justified = {4'h0, sample_reg};
        end
    end

    sarcc_window u_win (
        .word       (justified),
        .ltLimit    (lt_reg),
        .gtLimit    (gt_reg),
        .signedMode (diffNow),
        .hit        (winHit)
    );

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sample_next = sample_reg;
        endConv = 1'b0;
        case (state_reg)
            sarcc_pkg::SARCC_IDLE: begin
                cnt_next = 5'h00;
                // a trigger in any other state is dropped
                if (trigger && convEnable) begin
                    // external start in low-power mode already tracked
                    if (trackingMode && !lowPowerExt) begin
                        state_next = sarcc_pkg::SARCC_TRACK;
                    end else begin
                        state_next = sarcc_pkg::SARCC_CONV;
                    end
                end
            end
            sarcc_pkg::SARCC_TRACK: begin
                if (sarTick) begin
                    if (cnt_reg == 5'(sarcc_pkg::TRACK_CLOCKS - 1)) begin
                        cnt_next = 5'h00;
                        state_next = sarcc_pkg::SARCC_CONV;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            sarcc_pkg::SARCC_CONV: begin
                if (sampleValid) begin
                    sample_next = sampleData;
                end
                if (sarTick) begin
                    if (cnt_reg == 5'(sarcc_pkg::CONV_CLOCKS - 1)) begin
                        state_next = sarcc_pkg::SARCC_FINISH;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            default: begin
                endConv = 1'b1;
                state_next = sarcc_pkg::SARCC_IDLE;
            end
        endcase
        if (!convEnable) begin
            state_next = sarcc_pkg::SARCC_IDLE;
            endConv = 1'b0;
        end
        // finish cycle included: busy falls with the flags
        busy_next = state_next != sarcc_pkg::SARCC_IDLE;
        // set wins over a clear in the same cycle
        done_next = endConv ? 1'b1 :
            (doneFlagClear ? 1'b0 : done_reg);
        irq_next = endConv && doneIntEnable;
        win_next = (endConv && winHit) ? 1'b1 :
            (windowFlagClear ? 1'b0 : windowFlag);
        word_next = endConv ? justified : word_reg;
        hold_next = busy_next && state_next == sarcc_pkg::SARCC_CONV;
        if (chipSleep || !convEnable) begin
            track_next = 1'b0;
        end else if (state_next == sarcc_pkg::SARCC_TRACK) begin
            track_next = 1'b1;
        end else if (state_next != sarcc_pkg::SARCC_IDLE) begin
            track_next = 1'b0;
        end else if (lowPowerExt) begin
            track_next = !extLevel_next;
        end else begin
            track_next = !trackingMode;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sarcc_pkg::SARCC_IDLE;
            cnt_reg <= 5'h00;
            sample_reg <= 12'h000;
            word_reg <= 16'h0000;
            done_reg <= 1'b0;
            convBusy <= 1'b0;
            convDoneFlag <= 1'b0;
            doneIrq <= 1'b0;
            windowFlag <= 1'b0;
            resultHighByte <= 8'h00;
            resultLowByte <= 8'h00;
            analogPowerOn <= 1'b0;
            trackEnable <= 1'b0;
            holdSample <= 1'b0;
            channelSelect <= sarcc_pkg::CHAN_RESET;
            pairConfig <= sarcc_pkg::PAIR_RESET;
            gainSelect <= sarcc_pkg::GAIN_RESET;
            diffChannel <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sample_reg <= sample_next;
            word_reg <= word_next;
            done_reg <= done_next;
            convBusy <= busy_next;
            convDoneFlag <= done_next;
            doneIrq <= irq_next;
            windowFlag <= win_next;
            resultHighByte <= word_next[15:8];
            resultLowByte <= word_next[7:0];
            analogPowerOn <= convEnable;
            trackEnable <= track_next;
            holdSample <= hold_next;
            channelSelect <= chan_next;
            pairConfig <= pair_next;
            gainSelect <= gain_next;
            diffChannel <= isDiff(chan_next, pair_next);
        end
    end
endmodule

// File: sarcc_monitor.sv
// Purpose: port assertions for the converter control
// Assumes: ce held high, divider between 100 and 255
// Notes:   bound at the foot of this file
`timescale 1ns/1ns
module sarcc_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       convEnable,
    input wire logic [1:0] startMode,
    input wire logic       swStart,
    input wire logic       timer3Overflow,
    input wire logic       timer2Overflow,
    input wire logic       chipSleep,
    input wire logic       trackingMode,
    input wire logic       leftJustify,
    input wire logic       doneIntEnable,
    input wire logic       convBusy,
    input wire logic       convDoneFlag,
    input wire logic       doneIrq,
    input wire logic       windowFlag,
    input wire logic [7:0] resultHighByte,
    input wire logic [7:0] resultLowByte,
    input wire logic       analogPowerOn,
    input wire logic       trackEnable,
    input wire logic       diffChannel
);
    // busy length; a restart would overrun the bound
    logic [12:0] busyLen_reg;
    logic [12:0] busyLen_next;
    logic        trig;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    always_comb begin
        busyLen_next = convBusy ? busyLen_reg + 13'h1 : 13'h0;
        trig = (startMode == sarcc_pkg::SARCC_START_SW && swStart)
            || (startMode == sarcc_pkg::SARCC_START_T3 && timer3Overflow)
            || (startMode == sarcc_pkg::SARCC_START_T2 && timer2Overflow);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            busyLen_reg <= 13'h0;
        else
            busyLen_reg <= busyLen_next;
    end

    chk_start_taken: assert property (
        convEnable && analogPowerOn && !convBusy && trig |=> convBusy)
        else $error("trigger ignored");
    chk_shutdown_idle: assert property (
        !convEnable |=> !convBusy)
        else $error("busy while disabled");
    chk_done_on_fall: assert property (
        $fell(convBusy) && $past(convEnable) |-> convDoneFlag)
        else $error("done flag missing");
    chk_irq_cause: assert property (
        doneIrq |-> $fell(convBusy) && $past(doneIntEnable))
        else $error("stray irq");
    chk_irq_single: assert property (
        doneIrq |=> !doneIrq)
        else $error("irq too long");
    chk_conv_length: assert property (
        $fell(convBusy) && $past(convEnable)
        |-> busyLen_reg >= 13'd1600 && busyLen_reg <= 13'd4900)
        else $error("bad conversion length");
    chk_result_hold: assert property (
        !$fell(convBusy) |-> $stable({resultHighByte, resultLowByte}))
        else $error("result changed");
    chk_window_cause: assert property (
        $rose(windowFlag) |-> $fell(convBusy))
        else $error("stray window flag");
    chk_left_zero: assert property (
        $fell(convBusy) && $past(convEnable) && leftJustify
        |-> resultLowByte[3:0] == 4'h0)
        else $error("low nibble not zero");
    chk_sign_ext: assert property (
        $fell(convBusy) && $past(convEnable) && !leftJustify
        |-> resultHighByte[7:4]
            == (diffChannel ? {4{resultHighByte[3]}} : 4'h0))
        else $error("bad sign extension");
    chk_sleep_track: assert property (
        chipSleep |=> !trackEnable)
        else $error("tracking during sleep");
    chk_track_idle: assert property (
        analogPowerOn && $past(analogPowerOn) && !trackingMode
        && !$past(trackingMode) && !chipSleep && !$past(chipSleep)
        && !convBusy && !$past(convBusy) |-> trackEnable)
        else $error("not tracking while idle");
endmodule

bind sar_adc_conversion_control sarcc_monitor u_mon (.clk, .arst_n,
    .convEnable, .startMode, .swStart, .timer3Overflow, .timer2Overflow,
    .chipSleep, .trackingMode, .leftJustify, .doneIntEnable, .convBusy,
    .convDoneFlag, .doneIrq, .windowFlag, .resultHighByte, .resultLowByte,
    .analogPowerOn, .trackEnable, .diffChannel);

// File: sarcc_core_model.sv
// Purpose: analog core model, one sample per conversion
// Assumes: sample taken only while holding, not tracking
// Notes:   data toggles outside the strobe
`timescale 1ns/1ns
module sarcc_core_model (
    input wire logic        clk,
    input wire logic        convBusy,
    input wire logic        holdSample,
    input wire logic        trackEnable,
    input wire logic [11:0] nextSample,
    input wire logic [9:0]  delay,
    output logic            sampleValid,
    output logic [11:0]     sampleData
);
    logic [9:0] cnt;
    logic       sent;

    initial begin
        cnt = 10'h0;
        sent = 1'b0;
        sampleValid = 1'b0;
        sampleData = 12'h5a5;
    end

    always @(posedge clk) begin
        sampleValid <= 1'b0;
        sampleData <= ~sampleData;
        if (!convBusy || trackEnable || !holdSample) begin
            cnt <= 10'h0;
            sent <= 1'b0;
        end else if (!sent) begin
            cnt <= cnt + 10'h1;
            if (cnt == delay) begin
                sampleValid <= 1'b1;
                sampleData <= nextSample;
                sent <= 1'b1;
            end
        end
    end
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for converter control
// Assumes: divider at or above the clamp
// Notes:   expectations queued by the driver, popped on busy fall
`timescale 1ns/1ns
module tb_top;
    logic        clk, arst_n, ce, convEnable, swStart, timer3Overflow;
    logic        timer2Overflow, extConvertStart, chipSleep, trackingMode;
    logic        leftJustify, doneFlagClear, windowFlagClear, doneIntEnable;
    logic        cfgWrite, sampleValid, convBusy, convDoneFlag, doneIrq;
    logic        windowFlag, analogPowerOn, trackEnable, holdSample;
    logic        diffChannel, busyWas, aborting, curDiff;
    logic [1:0]  startMode;
    logic [3:0]  channelSelIn, pairConfigIn, channelSelect, pairConfig;
    logic [2:0]  gainSelIn, gainSelect;
    logic [7:0]  clockDividerIn, resultHighByte, resultLowByte;
    logic [15:0] ltLimitIn, gtLimitIn;
    logic [11:0] sampleData, nextSample;
    logic [9:0]  coreDelay;
    logic [18:0] expQ[$];
    logic [2:0]  gainCodes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    int          bad_count, checks, k;
    int          seed = 32'h1d7b3121;

    sar_adc_conversion_control u_dut (.clk, .arst_n, .ce, .convEnable,
        .startMode, .swStart, .timer3Overflow, .timer2Overflow,
        .extConvertStart, .chipSleep, .trackingMode, .leftJustify,
        .doneFlagClear, .windowFlagClear, .doneIntEnable, .cfgWrite,
        .channelSelIn, .pairConfigIn, .gainSelIn, .clockDividerIn,
        .ltLimitIn, .gtLimitIn, .sampleValid, .sampleData, .convBusy,
        .convDoneFlag, .doneIrq, .windowFlag, .resultHighByte,
        .resultLowByte, .analogPowerOn, .trackEnable, .holdSample,
        .channelSelect, .pairConfig, .gainSelect, .diffChannel);
    sarcc_core_model u_core (.clk, .convBusy, .holdSample, .trackEnable,
        .nextSample, .delay(coreDelay), .sampleValid, .sampleData);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic waitBusy(logic v, int lim);
        for (int i = 0; i < lim && convBusy !== v; i++) step(1);
        if (convBusy !== v) begin
            check(convBusy, v);
            test_done();
        end
    endtask

    task automatic cfg(logic [3:0] ch, logic [3:0] pr, logic [2:0] g,
                       logic [7:0] dv, logic [15:0] lt, logic [15:0] gt);
        channelSelIn = ch;
        pairConfigIn = pr;
        gainSelIn = g;
        clockDividerIn = dv;
        ltLimitIn = lt;
        gtLimitIn = gt;
        curDiff = !ch[3] && pr[ch[2:1]];
        cfgWrite = 1'b1;
        step(1);
        cfgWrite = 1'b0;
        step(1);
    endtask

    // {irq, window, done, high byte, low byte}
    function automatic logic [18:0] expectF(logic [11:0] s);
        logic [15:0]        w;
        logic signed [16:0] a, l, g;
        logic               hit;
        w = leftJustify ? {s, 4'h0} : {(curDiff ? {4{s[11]}} : 4'h0), s};
        a = {curDiff & w[15], w};
        l = {curDiff & ltLimitIn[15], ltLimitIn};
        g = {curDiff & gtLimitIn[15], gtLimitIn};
        hit = (l > g) ? (a > g && a < l) : (a < l || a > g);
        return {doneIntEnable, hit, 1'b1, w};
    endfunction

    // unselected sources fire first and must be ignored
    task automatic conv(logic [1:0] m, logic [11:0] s);
        nextSample = s;
        startMode = m;
        {doneFlagClear, windowFlagClear} = 2'h3;
        {timer2Overflow, extConvertStart, timer3Overflow, swStart} =
            ~(4'h1 << m);
        step(1);
        {doneFlagClear, windowFlagClear} = 2'h0;
        {swStart, timer3Overflow, timer2Overflow} = 3'h0;
        step(8);
        extConvertStart = 1'b0;
        step(8);
        check(convBusy, 1'b0);
        expQ.push_back(expectF(s));
        {timer2Overflow, extConvertStart, timer3Overflow, swStart} =
            4'h1 << m;
        step(1);
        {swStart, timer3Overflow, timer2Overflow} = 3'h0;
        waitBusy(1'b1, 40);
        step(30);
        {swStart, timer3Overflow, timer2Overflow} = 3'h7;
        step(1);
        {swStart, timer3Overflow, timer2Overflow} = 3'h0;
        waitBusy(1'b0, 6000);
        step(3);
        extConvertStart = 1'b0;
    endtask

    always @(negedge clk) begin
        if (busyWas === 1'b1 && convBusy === 1'b0 && !aborting) begin
            if (expQ.size() == 0)
                check(32'h1, 32'h0);
            else
                check({doneIrq, windowFlag, convDoneFlag, resultHighByte,
                       resultLowByte}, expQ.pop_front());
        end
        busyWas = convBusy;
    end

    initial begin
        {arst_n, convEnable, swStart, timer3Overflow, timer2Overflow} = 5'h0;
        {extConvertStart, chipSleep, trackingMode, leftJustify} = 4'h0;
        {doneFlagClear, windowFlagClear, doneIntEnable, cfgWrite} = 4'h0;
        {busyWas, aborting, curDiff} = 3'h0;
        ce = 1'b1;
        startMode = 2'h0;
        {channelSelIn, pairConfigIn, gainSelIn} = 11'h0;
        clockDividerIn = 8'hff;
        {ltLimitIn, gtLimitIn} = 32'h0;
        nextSample = 12'h0;
        coreDelay = 10'h3;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        step(3);
        check({channelSelect, pairConfig, gainSelect, analogPowerOn,
               convBusy, windowFlag}, {sarcc_pkg::CHAN_RESET,
               sarcc_pkg::PAIR_RESET, sarcc_pkg::GAIN_RESET, 3'h0});
        for (k = 0; k < 16; k++) begin
            cfg(k[3:0], $random(seed), gainCodes[k % 6], 8'h64, 0, 0);
            check({channelSelect, gainSelect, diffChannel}, {(k < 8 ?
                   k[3:0] : sarcc_pkg::CHAN_TEMP), gainCodes[k % 6],
                   curDiff});
        end
        convEnable = 1'b1;
        step(2);
        check(analogPowerOn, 1'b1);
        for (k = 0; k < 8; k++) begin
            trackingMode = k[2];
            leftJustify = k[0] ^ k[2];
            doneIntEnable = k[1];
            coreDelay = k[2] ? 10'd900 : 10'd3;
            cfg(4'h0, {3'h0, k[0]}, 3'h0, 8'd100 + 8'(k * 4),
                k[0] ? 16'hfff0 : 16'h1000, k[0] ? 16'h1000 : 16'hfff0);
            conv(k[1:0], k < 2 ? 12'h100 : 12'($random(seed)));
        end
        aborting = 1'b1;
        startMode = 2'h0;
        swStart = 1'b1;
        step(1);
        swStart = 1'b0;
        step(50);
        convEnable = 1'b0;
        waitBusy(1'b0, 5);
        step(2);
        check(analogPowerOn, 1'b0);
        convEnable = 1'b1;
        aborting = 1'b0;
        step(3);
        conv(2'h0, 12'h800);
        chipSleep = 1'b1;
        step(3);
        check(trackEnable, 1'b0);
        chipSleep = 1'b0;
        trackingMode = 1'b0;
        step(4);
        check(trackEnable, 1'b1);
        trackingMode = 1'b1;
        step(4);
        check(trackEnable, 1'b0);
        check(expQ.size(), 0);
        test_done();
    end
endmodule
